// file: include/motor_gate_map.svh
`ifndef MOTOR_GATE_MAP_SVH
`define MOTOR_GATE_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define ADDR_MONITOR        4'h0
`define ADDR_DEAD_TIME      4'h1
`define ADDR_POLARITY       4'h2
`define ADDR_HALL_CONTROL   4'h3
`define ADDR_SOFT_SENSOR    4'h4
`define ADDR_FILTER_CONTROL 4'h5
`define ADDR_FILTER_COUNT   4'h6
`define ADDR_OUTPUT_ENABLE  4'h7

// ****************************************************************
// field positions
// ****************************************************************
`define DT_LENGTH_MSB       4
`define DT_ENABLE_BIT       5
`define DT_CLKSEL_LSB       6
`define HC_DECODER_EN_BIT   0
`define HC_SOURCE_BIT       1
`define HC_DELAY_SEL_BIT    2
`define HC_TIMER_LSB        3
`define FC_RATE_MSB         3
`define FC_ENABLE_BIT       4

// ****************************************************************
// reset values
// ****************************************************************
`define RESET_DEAD_TIME     8'h00
`define RESET_POLARITY      6'h00
`define RESET_HALL_CONTROL  5'h00
`define RESET_SOFT_SENSOR   3'h0
`define RESET_FILTER_CTRL   5'h00
`define RESET_FILTER_COUNT  5'h00

// ****************************************************************
// clock divide masks
// ****************************************************************
`define DIV_BY_1_MASK       3'h0
`define DIV_BY_2_MASK       3'h1
`define DIV_BY_4_MASK       3'h3
`define DIV_BY_8_MASK       3'h7

`endif

// file: include/motor_gate_pkg.sv
package motor_gate_pkg;

  typedef enum logic [0:0] {
    delay_idle,
    delay_wait
  } delay_state_t;

  typedef struct packed {
    logic       prev;
    logic [5:0] cnt;
    logic       out;
  } channel_state_t;

  typedef struct packed {
    logic [7:0]      dead_time;
    logic [5:0]      polarity;
    logic [4:0]      hall_control;
    logic [2:0]      soft_sensor;
    logic [4:0]      filter_control;
    logic [4:0]      filter_count;
    logic            drive_enable;
    logic [7:0]      rdata;
    logic [2:0]      div_cnt;
    logic [3:0]      prescale;
    logic [2:0]      filtered;
    logic [2:0][4:0] match_cnt;
    logic [5:0]      gate_out;
    logic [2:0]      buffer_first;
    logic [2:0]      buffer_second;
    delay_state_t    delay_state;
    logic [2:0]      timer_run;
  } core_state_t;

endpackage : motor_gate_pkg

// file: rtl/deadband_channel.sv
`timescale 1ns/10ps
`include "motor_gate_map.svh"

module deadband_channel
  import motor_gate_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       request,
  input  wire logic       tick,
  input  wire logic       enable,
  input  wire logic [4:0] length,
  output logic            out
);

  channel_state_t s_reg;
  channel_state_t s_next;

  always_comb
  begin
    s_next      = s_reg;
    s_next.prev = request;
    if (!request)
    begin
      // falls pass at once and cancel any pending rise
      s_next.cnt = 6'h00; // R4 R21
      s_next.out = 1'b0; // R4
    end
    else if (!s_reg.prev)
    begin
      if (!enable)
      begin
        s_next.cnt = 6'h00;
        s_next.out = 1'b1; // R5
      end
      else
      begin
        // every new rise restarts the count
        s_next.cnt = {1'b0, length} + 6'h01; // R6 R21
        s_next.out = 1'b0; // R3
      end
    end
    else if (!enable)
    begin
      s_next.cnt = 6'h00;
      s_next.out = 1'b1; // R5
    end
    else if ((s_reg.cnt != 6'h00) && tick)
    begin
      s_next.cnt = s_reg.cnt - 6'h01; // R3
      if (s_reg.cnt == 6'h01)
      begin
        s_next.out = 1'b1; // R3
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign out = s_reg.out;

endmodule : deadband_channel

// file: rtl/motor_gate_drive.sv
// Notes on behaviour
// R1: status bits 5:3 show A/B gate outputs
// R2: status bits 2:0 show filtered sensors
// R3: each gate rise delayed by dead time
// R4: gate falls pass with no delay
// R5: deadband enable zero gives zero dead time
// R6: dead time is length plus one ticks
// R7: clock select divides by 1,2,4,8
// R8: both pair inputs high forces both low
// R9: logic one means transistor on
// R10: six polarity bits invert gate outputs
// R11: gate pins undriven until enabled
// R12: source select picks real or soft sensors
// R13: filter enable switches noise filter on
// R14: count times sample period sets filter delay
// R15: delay select low clears buffers, frees timers
// R16: delay select high, hardware owns timer run
// R17: software orders table, timer, mode, decoder enable
// R18: software prepares timer before delay enabled
// R19: software keeps delay within one step
// R20: timer choice 00,01,10 picks timer; 11 none
// R21: rises restart count; early fall cancels
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`include "motor_gate_map.svh"

module motor_gate_drive
  import motor_gate_pkg::*;
#(
  parameter int CHANNELS = 6
)
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic [5:0] gate_request,
  input  wire logic [2:0] sensor_in,
  output logic      [2:0] sensor_to_decoder,
  output logic            decoder_enable,
  output logic      [2:0] timer_run,
  output logic      [2:0] timer_run_owned,
  input  wire logic [2:0] timer_compare_match,
  output logic            phase_a_high_side_out,
  output logic            phase_a_high_side_oe,
  output logic            phase_a_low_side_out,
  output logic            phase_a_low_side_oe,
  output logic            phase_b_high_side_out,
  output logic            phase_b_high_side_oe,
  output logic            phase_b_low_side_out,
  output logic            phase_b_low_side_oe,
  output logic            phase_c_high_side_out,
  output logic            phase_c_high_side_oe,
  output logic            phase_c_low_side_out,
  output logic            phase_c_low_side_oe
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_sync_reg <= 2'b00;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ****************************************************************
  // state and decoded fields
  // ****************************************************************
  core_state_t s_reg;
  core_state_t s_next;

  logic [CHANNELS-1:0] deadband_out;
  logic                deadband_tick;
  logic [2:0]          div_mask;
  logic [1:0]          deadband_clock_select;
  logic                deadband_enable;
  logic [4:0]          deadband_length;
  logic                sensor_source_select;
  logic                sensor_delay_select;
  logic [1:0]          delay_timer_choice;
  logic                sensor_filter_enable;
  logic [3:0]          filter_sample_rate;
  logic [4:0]          filter_match_count;
  logic [2:0]          sensor_source;
  logic [2:0]          timer_chosen;
  logic [2:0]          filtered_sensor;

  assign deadband_clock_select = s_reg.dead_time[`DT_CLKSEL_LSB +: 2];
  assign deadband_enable       = s_reg.dead_time[`DT_ENABLE_BIT];
  assign deadband_length       = s_reg.dead_time[`DT_LENGTH_MSB:0];
  assign sensor_source_select  = s_reg.hall_control[`HC_SOURCE_BIT];
  assign sensor_delay_select   = s_reg.hall_control[`HC_DELAY_SEL_BIT];
  assign delay_timer_choice    = s_reg.hall_control[`HC_TIMER_LSB +: 2];
  assign sensor_filter_enable  = s_reg.filter_control[`FC_ENABLE_BIT];
  assign filter_sample_rate    = s_reg.filter_control[`FC_RATE_MSB:0];
  assign filter_match_count    = s_reg.filter_count;
  assign filtered_sensor       = s_reg.filtered;

  // ****************************************************************
  // deadband clock
  // ****************************************************************
  always_comb
  begin
    unique case (deadband_clock_select)
      2'b00: div_mask = `DIV_BY_1_MASK; // R7
      2'b01: div_mask = `DIV_BY_2_MASK; // R7
      2'b10: div_mask = `DIV_BY_4_MASK; // R7
      2'b11: div_mask = `DIV_BY_8_MASK; // R7
    endcase
  end

  // the tick phase is free running, so the first tick of a delay may come early by up to one divided period
  assign deadband_tick = ((s_reg.div_cnt & div_mask) == div_mask); // R7

  // ****************************************************************
  // deadband channels
  // ****************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_deadband
      deadband_channel u_channel (
        .clk     (clk),
        .rst_n   (rst_n),
        .request (gate_request[ch]),
        .tick    (deadband_tick),
        .enable  (deadband_enable),
        .length  (deadband_length),
        .out     (deadband_out[ch])
      ); // R3
    end
  endgenerate

  // ****************************************************************
  // timer ownership
  // ****************************************************************
  always_comb
  begin
    timer_chosen = 3'h0;
    for (int t = 0; t < 3; t++)
    begin
      timer_chosen[t] = (delay_timer_choice == t[1:0]); // R20
    end
  end

  assign sensor_source = sensor_source_select ? sensor_in : s_reg.soft_sensor; // R12

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic [5:0] match_inc;
    logic       sample_tick;
    logic       top;
    logic       bottom;
    logic [5:0] staggered;
    match_inc   = 6'h00;
    sample_tick = 1'b0;
    top         = 1'b0;
    bottom      = 1'b0;
    staggered   = 6'h00;
    s_next      = s_reg;
    s_next.div_cnt = s_reg.div_cnt + 3'h1;

    // register writes
    if (wr)
    begin
      unique case (addr)
        `ADDR_DEAD_TIME:      s_next.dead_time      = wdata;
        `ADDR_POLARITY:       s_next.polarity       = wdata[5:0]; // R10
        `ADDR_HALL_CONTROL:   s_next.hall_control   = wdata[4:0];
        `ADDR_SOFT_SENSOR:    s_next.soft_sensor    = wdata[2:0];
        `ADDR_FILTER_CONTROL: s_next.filter_control = wdata[4:0];
        `ADDR_FILTER_COUNT:   s_next.filter_count   = wdata[4:0];
        `ADDR_OUTPUT_ENABLE:  s_next.drive_enable   = wdata[0]; // R11
        default:              s_next.dead_time      = s_reg.dead_time;
      endcase
    end

    // read data stand for one cycle only
    s_next.rdata = 8'h00;
    if (rd)
    begin
      unique case (addr)
        `ADDR_MONITOR:        s_next.rdata = {2'b00, s_reg.gate_out[0], s_reg.gate_out[1],
                                              s_reg.gate_out[2], s_reg.filtered[2:0]}; // R1 R2
        `ADDR_DEAD_TIME:      s_next.rdata = s_reg.dead_time;
        `ADDR_POLARITY:       s_next.rdata = {2'b00, s_reg.polarity};
        `ADDR_HALL_CONTROL:   s_next.rdata = {3'b000, s_reg.hall_control};
        `ADDR_SOFT_SENSOR:    s_next.rdata = {5'h00, s_reg.soft_sensor};
        `ADDR_FILTER_CONTROL: s_next.rdata = {3'b000, s_reg.filter_control};
        `ADDR_FILTER_COUNT:   s_next.rdata = {3'b000, s_reg.filter_count};
        `ADDR_OUTPUT_ENABLE:  s_next.rdata = {7'h00, s_reg.drive_enable};
        default:              s_next.rdata = 8'h00;
      endcase
    end

    // noise filter: a new level is taken after count consecutive differing samples
    sample_tick = (s_reg.prescale == filter_sample_rate);
    if (!sensor_filter_enable)
    begin
      // filter off: the raw source passes straight through
      s_next.filtered  = sensor_source; // R13
      s_next.match_cnt = '0; // R13
      s_next.prescale  = 4'h0;
    end
    else
    begin
      s_next.prescale = sample_tick ? 4'h0 : s_reg.prescale + 4'h1; // R14
      if (sample_tick)
      begin
        for (int h = 0; h < 3; h++)
        begin
          match_inc = {1'b0, s_reg.match_cnt[h]} + 6'h01;
          if (sensor_source[h] == s_reg.filtered[h])
          begin
            s_next.match_cnt[h] = 5'h00; // R14
          end
          else if (match_inc >= {1'b0, filter_match_count})
          begin
            s_next.filtered[h]  = sensor_source[h]; // R14
            s_next.match_cnt[h] = 5'h00;
          end
          else
          begin
            s_next.match_cnt[h] = match_inc[4:0]; // R14
          end
        end
      end
    end

    // sensor delay path on the borrowed timer
    if (!sensor_delay_select)
    begin
      s_next.buffer_first  = 3'h0; // R15
      s_next.buffer_second = 3'h0; // R15
      s_next.timer_run     = 3'h0; // R15
      s_next.delay_state   = delay_idle;
    end
    else
    begin
      unique case (s_reg.delay_state)
        delay_idle:
        begin
          if (s_reg.filtered != s_reg.buffer_first)
          begin
            s_next.buffer_first = s_reg.filtered;
            s_next.timer_run    = timer_chosen; // R16 R20
            s_next.delay_state  = delay_wait;
          end
        end
        delay_wait:
        begin
          // a change during the wait is only tracked; the delay must stay within one step
          s_next.buffer_first = s_reg.filtered; // R19
          if ((timer_compare_match & timer_chosen) != 3'h0)
          begin
            s_next.buffer_second = s_reg.buffer_first; // R16
            s_next.timer_run     = 3'h0; // R16
            s_next.delay_state   = delay_idle;
          end
        end
      endcase
    end

    // shoot-through guard per pair, then polarity
    for (int p = 0; p < 3; p++)
    begin
      top    = deadband_out[2*p];
      bottom = deadband_out[2*p+1];
      staggered[2*p]   = top & ~bottom; // R8
      staggered[2*p+1] = bottom & ~top; // R8
    end
    // a one from the guard means transistor on unless the output is inverted
    s_next.gate_out = staggered ^ s_reg.polarity; // R9 R10
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg                <= '0;
      s_reg.dead_time      <= `RESET_DEAD_TIME;
      s_reg.polarity       <= `RESET_POLARITY;
      s_reg.hall_control   <= `RESET_HALL_CONTROL;
      s_reg.soft_sensor    <= `RESET_SOFT_SENSOR;
      s_reg.filter_control <= `RESET_FILTER_CTRL;
      s_reg.filter_count   <= `RESET_FILTER_COUNT;
      s_reg.delay_state    <= delay_idle;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata             = s_reg.rdata;
  assign decoder_enable    = s_reg.hall_control[`HC_DECODER_EN_BIT];
  assign sensor_to_decoder = sensor_delay_select ? s_reg.buffer_second : filtered_sensor; // R16
  assign timer_run         = s_reg.timer_run;
  assign timer_run_owned   = sensor_delay_select ? timer_chosen : 3'h0; // R15 R16

  // pins stay undriven until software enables the drive
  assign phase_a_high_side_out = s_reg.gate_out[0];
  assign phase_a_low_side_out  = s_reg.gate_out[1];
  assign phase_b_high_side_out = s_reg.gate_out[2];
  assign phase_b_low_side_out  = s_reg.gate_out[3];
  assign phase_c_high_side_out = s_reg.gate_out[4];
  assign phase_c_low_side_out  = s_reg.gate_out[5];
  assign phase_a_high_side_oe  = s_reg.drive_enable; // R11
  assign phase_a_low_side_oe   = s_reg.drive_enable; // R11
  assign phase_b_high_side_oe  = s_reg.drive_enable; // R11
  assign phase_b_low_side_oe   = s_reg.drive_enable; // R11
  assign phase_c_high_side_oe  = s_reg.drive_enable; // R11
  assign phase_c_low_side_oe   = s_reg.drive_enable; // R11

endmodule : motor_gate_drive

// file: verification/hall_timer_model.sv
`timescale 1ns/10ps
// ****
// sensors and delay timers
// ****
module hall_timer_model (
  input  wire logic       clk,
  input  wire logic [2:0] hall_level,
  input  wire logic [7:0] compare_a,
  input  wire logic [2:0] run,
  output logic      [2:0] sensor_in,
  output logic      [2:0] compare_match
);
  logic [7:0] count_reg [3];

  // clean levels; glitches are made by the bench itself
  assign sensor_in = hall_level;

  // compare mode, cleared on a match; compare_a kept short of one sensor step
  always_ff @(posedge clk)
    for (int i = 0; i < 3; i++)
      if (!run[i] || count_reg[i] == compare_a)
        count_reg[i] <= 8'h00;
      else
        count_reg[i] <= count_reg[i] + 8'h01;

  always_comb
    for (int i = 0; i < 3; i++)
      compare_match[i] = run[i] && count_reg[i] == compare_a;
endmodule : hall_timer_model

// file: verification/motor_gate_drive_properties.sv
`timescale 1ns/10ps
// ****
// port checks
// ****
module motor_gate_checks (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic [5:0] gate_request,
  input wire logic [2:0] timer_run,
  input wire logic [2:0] timer_run_owned,
  input wire logic [2:0] timer_compare_match,
  input wire logic       phase_a_high_side_out,
  input wire logic       phase_a_high_side_oe,
  input wire logic       phase_a_low_side_out,
  input wire logic       phase_b_high_side_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // shadow of the polarity register, so pin levels can be judged from the ports alone
  logic [5:0] pol_reg;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      pol_reg <= 6'h00;
    else if (wr && addr == 4'h2)
      pol_reg <= wdata[5:0];

  property p_rdata_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero");
  property p_monitor;
    rd && addr == 4'h0 |=> rdata[7:3] == {2'b00, $past(phase_a_high_side_out),
      $past(phase_a_low_side_out), $past(phase_b_high_side_out)};
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("monitor gate bits wrong");
  property p_oe;
    wr && addr == 4'h7 |=> phase_a_high_side_oe == $past(wdata[0]);
  endproperty
  a_oe: assert property (p_oe)
    else $error("drive enable wrong");
  property p_stagger;
    (gate_request[1:0] == 2'b11 && $stable(pol_reg)) [*4]
      |-> {phase_a_high_side_out, phase_a_low_side_out} == {pol_reg[0], pol_reg[1]};
  endproperty
  a_stagger: assert property (p_stagger)
    else $error("pair not forced off");
  property p_fall;
    $fell(gate_request[2]) ##0 (!gate_request[2] && $stable(pol_reg)) [*4]
      |-> phase_b_high_side_out == pol_reg[2];
  endproperty
  a_fall: assert property (p_fall)
    else $error("fall delayed");
  property p_owned;
    (timer_run & ~timer_run_owned) == 3'h0;
  endproperty
  a_owned: assert property (p_owned)
    else $error("run bit on unowned timer");
  property p_match_stop;
    (timer_run & timer_compare_match) != 3'h0 |=> timer_run == 3'h0;
  endproperty
  a_match_stop: assert property (p_match_stop)
    else $error("timer not stopped on match");
  property p_dt_back;
    wr && addr == 4'h1 ##1 !wr ##1 rd && addr == 4'h1 |=> rdata == $past(wdata, 3);
  endproperty
  a_dt_back: assert property (p_dt_back)
    else $error("dead time read back wrong");

  c_stagger: cover property (gate_request[1:0] == 2'b11);
  c_match: cover property ((timer_run & timer_compare_match) != 3'h0);
  c_monitor: cover property (rd && addr == 4'h0);
endmodule : motor_gate_checks

bind motor_gate_drive motor_gate_checks u_checks (.clk, .reset_n, .addr, .wdata, .wr, .rd, .rdata,
  .gate_request, .timer_run, .timer_run_owned, .timer_compare_match, .phase_a_high_side_out,
  .phase_a_high_side_oe, .phase_a_low_side_out, .phase_b_high_side_out);

// file: verification/tb_motor_gate_drive.sv
`timescale 1ns/10ps
`include "motor_gate_map.svh"
// ****
// bench
// ****
module tb_motor_gate_drive;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [5:0] gate_request = 6'h00;
  logic [2:0] hall_level = 3'h0;
  logic [7:0] rdata;
  logic [2:0] sensor_in, sensor_to_decoder, timer_run, timer_run_owned, timer_compare_match;
  logic       decoder_enable;
  logic [5:0] pin, oe, exp;
  int         n_mismatch = 0;
  int         n_checks = 0;
  int         cycles = 0;
  int         n, lf;

  motor_gate_drive u_dut (.clk, .reset_n, .addr, .wdata, .wr, .rd, .rdata, .gate_request, .sensor_in,
    .sensor_to_decoder, .decoder_enable, .timer_run, .timer_run_owned, .timer_compare_match,
    .phase_a_high_side_out(pin[0]), .phase_a_high_side_oe(oe[0]), .phase_a_low_side_out(pin[1]),
    .phase_a_low_side_oe(oe[1]), .phase_b_high_side_out(pin[2]), .phase_b_high_side_oe(oe[2]),
    .phase_b_low_side_out(pin[3]), .phase_b_low_side_oe(oe[3]), .phase_c_high_side_out(pin[4]),
    .phase_c_high_side_oe(oe[4]), .phase_c_low_side_out(pin[5]), .phase_c_low_side_oe(oe[5]));

  hall_timer_model u_far (.clk, .hall_level, .compare_a(8'h14), .run(timer_run), .sensor_in,
    .compare_match(timer_compare_match));

  always #4 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] want);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, want);
  endtask : rd_reg

  task automatic wait_cycles(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : wait_cycles

  // cycles from the driving edge until the pin follows; capped so a stuck pin cannot hang
  task automatic edge_time(input int ch, input logic lvl, output int k);
    @(posedge clk);
    gate_request[ch] <= lvl;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end while (pin[ch] !== lvl && k < 400);
  endtask : edge_time

  task automatic wait_sensor(input logic [2:0] v, output int k);
    k = 0;
    while (sensor_to_decoder !== v && k < 400)
    begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask : wait_sensor

  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(`ADDR_MONITOR, 8'h00);
    rd_reg(`ADDR_DEAD_TIME, 8'h00);
    rd_reg(`ADDR_POLARITY, 8'h00);
    rd_reg(4'hf, 8'h00);
    check({2'b00, oe}, 8'h00);
    wr_reg(`ADDR_OUTPUT_ENABLE, 8'h01);
    wr_reg(`ADDR_MONITOR, 8'hff);
    wr_reg(`ADDR_DEAD_TIME, 8'he5);
    rd_reg(`ADDR_DEAD_TIME, 8'he5);
    check({2'b00, oe}, 8'h3f);
    rd_reg(`ADDR_MONITOR, 8'h00);
    wr_reg(`ADDR_DEAD_TIME, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(`ADDR_POLARITY, 8'hc0 | (8'h01 << i));
      wait_cycles(4);
      check({2'b00, pin}, 8'h01 << i);
    end
    rd_reg(`ADDR_POLARITY, 8'h20);
    wr_reg(`ADDR_POLARITY, 8'h00);
    for (int r = 0; r < 4; r++)
    begin
      @(posedge clk);
      gate_request <= {3{2'(r)}};
      wait_cycles(4);
      exp = (r == 3) ? 6'h00 : {3{2'(r)}};
      check({2'b00, pin}, {2'b00, exp});
      rd_reg(`ADDR_MONITOR, {2'b00, exp[0], exp[1], exp[2], 3'h0});
    end
    @(posedge clk);
    gate_request <= 6'h00;
    wait_cycles(4);
    edge_time(0, 1'b1, n);
    edge_time(0, 1'b0, lf);
    check(8'(n), 8'(lf));
    check(8'(lf), 8'h02);
    wr_reg(`ADDR_DEAD_TIME, 8'h24);
    for (int ch = 0; ch < 6; ch++)
    begin
      edge_time(ch, 1'b1, n);
      check(8'(n), 8'(lf + 5));
      edge_time(ch, 1'b0, n);
      check(8'(n), 8'(lf));
    end
    for (int d = 1; d < 4; d++)
    begin
      wr_reg(`ADDR_DEAD_TIME, 8'(d << 6) | 8'h22);
      edge_time(0, 1'b1, n);
      check(8'(n >= lf + 2 * (1 << d) + 1 && n <= lf + 3 * (1 << d)), 8'h01);
      edge_time(0, 1'b0, n);
    end
    // an early fall must cancel the pending rise, and the next rise count afresh
    wr_reg(`ADDR_DEAD_TIME, 8'h34);
    @(posedge clk);
    gate_request <= 6'h01;
    repeat (6) @(posedge clk);
    gate_request <= 6'h00;
    wait_cycles(30);
    check({7'h00, pin[0]}, 8'h00);
    edge_time(0, 1'b1, n);
    check(8'(n), 8'(lf + 21));
    edge_time(0, 1'b0, n);
    wr_reg(`ADDR_SOFT_SENSOR, 8'h05);
    wait_cycles(3);
    rd_reg(`ADDR_MONITOR, 8'h05);
    @(posedge clk);
    hall_level <= 3'h3;
    wr_reg(`ADDR_HALL_CONTROL, 8'h02);
    wait_cycles(3);
    rd_reg(`ADDR_MONITOR, 8'h03);
    wr_reg(`ADDR_FILTER_COUNT, 8'h04);
    wr_reg(`ADDR_FILTER_CONTROL, 8'h11);
    wait_cycles(12);
    @(posedge clk);
    hall_level <= 3'h6;
    wait_sensor(3'h6, n);
    check(8'(n >= 6 && n <= 11), 8'h01);
    @(posedge clk);
    hall_level <= 3'h1;
    repeat (3) @(posedge clk);
    hall_level <= 3'h6;
    #1;
    // a short glitch must not reach the filtered level
    check({5'h00, sensor_to_decoder}, 8'h06);
    wait_cycles(12);
    check({5'h00, sensor_to_decoder}, 8'h06);
    wr_reg(`ADDR_FILTER_CONTROL, 8'h00);
    for (int c = 0; c < 3; c++)
    begin
      wr_reg(`ADDR_HALL_CONTROL, 8'h02);
      wr_reg(`ADDR_HALL_CONTROL, 8'(c << 3) | 8'h06);
      wr_reg(`ADDR_HALL_CONTROL, 8'(c << 3) | 8'h07);
      #1;
      check({2'b00, timer_run, timer_run_owned}, {2'b00, 3'(1 << c), 3'(1 << c)});
      check({5'h00, sensor_to_decoder}, 8'h00);
      check({7'h00, decoder_enable}, 8'h01);
      wait_sensor(3'h6, n);
      check(8'(n >= 10 && n < 400), 8'h01);
      check({5'h00, timer_run}, 8'h00);
    end
    wr_reg(`ADDR_HALL_CONTROL, 8'h02);
    wr_reg(`ADDR_HALL_CONTROL, 8'h1e);
    wait_cycles(30);
    check({2'b00, timer_run, timer_run_owned}, 8'h00);
    check({5'h00, sensor_to_decoder}, 8'h00);
    stop_test();
  end
endmodule : tb_motor_gate_drive
